// ==== pdc_caps2_top.sv ====
/*
 * Device capabilities two register with its prefix-limit check, behind AHB-Lite.
 * Assumes implementation choices arrive as parameters fixed at elaboration.
 */
`timescale 1ns/10ps
module pdc_caps2_top #(
    parameter logic [1:0] MAX_PREFIX_COUNT = 2'h1,
    parameter logic PREFIX_SUPPORT = 1'b1,
    parameter logic WIDE_FORMAT_SUPPORT = 1'b0,
    parameter logic [1:0] BUFFER_FLUSH_FILL = 2'h0,
    parameter logic [1:0] PROCESSING_HINT = 2'h0,
    parameter logic LATENCY_REPORTING = 1'b0,
    parameter logic WIDE_SWAP_COMPLETER = 1'b0,
    parameter logic ATOMIC64_COMPLETER = 1'b0,
    parameter logic ATOMIC32_COMPLETER = 1'b0,
    parameter logic [3:0] TIMEOUT_RANGES = 4'h0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Received TLP descriptor
    input wire logic rx_tlp_valid,
    input wire logic [2:0] rx_tlp_prefix_count,
    output logic rx_tlp_malformed
);

    pdc_reg_if rif ();

    logic [31:0] device_capabilities_two;
    logic [2:0] prefix_limit;
    logic count_clear;
    logic [pdc_pkg::MALFORMED_COUNT_WIDTH-1:0] malformed_count;

    ////////////////////////////////////////////////////////////////////////////////
    // Capability word; every bit not placed here stays zero
    always_comb begin
        device_capabilities_two = 32'h0000_0000;
        device_capabilities_two[pdc_pkg::MAX_PREFIX_COUNT_LSB +: 2] = MAX_PREFIX_COUNT;
        device_capabilities_two[pdc_pkg::PREFIX_SUPPORT_FLAG_BIT] = PREFIX_SUPPORT;
        device_capabilities_two[pdc_pkg::WIDE_FORMAT_SUPPORT_FLAG_BIT] = WIDE_FORMAT_SUPPORT;
        device_capabilities_two[pdc_pkg::BUFFER_FLUSH_FILL_SUPPORT_LSB +: 2] =
            BUFFER_FLUSH_FILL;
        device_capabilities_two[pdc_pkg::PROCESSING_HINT_COMPLETER_SUPPORT_LSB +: 2] =
            pdc_pkg::pdc_hint_code(PROCESSING_HINT);
        device_capabilities_two[pdc_pkg::LATENCY_REPORTING_SUPPORT_FLAG_BIT] =
            LATENCY_REPORTING;
        device_capabilities_two[pdc_pkg::RELAXED_PASSING_FLAG_BIT] =
            pdc_pkg::RELAXED_PASSING_VALUE;
        device_capabilities_two[pdc_pkg::ATOMIC_ROUTING_FLAG_BIT] =
            pdc_pkg::ATOMIC_ROUTING_VALUE;
        device_capabilities_two[pdc_pkg::ALT_ROUTING_FORWARD_FLAG_BIT] =
            pdc_pkg::ALT_ROUTING_FORWARD_VALUE;
        device_capabilities_two[pdc_pkg::WIDE_SWAP_COMPLETER_FLAG_BIT] =
            WIDE_SWAP_COMPLETER;
        device_capabilities_two[pdc_pkg::ATOMIC64_COMPLETER_FLAG_BIT] = ATOMIC64_COMPLETER;
        device_capabilities_two[pdc_pkg::ATOMIC32_COMPLETER_FLAG_BIT] = ATOMIC32_COMPLETER;
        device_capabilities_two[pdc_pkg::TIMEOUT_DISABLE_SUPPORT_FLAG_BIT] =
            pdc_pkg::TIMEOUT_DISABLE_SUPPORT_VALUE;
        device_capabilities_two[pdc_pkg::TIMEOUT_RANGES_SUPPORT_LSB +: 4] =
            TIMEOUT_RANGES;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Limit follows the advertised field; without prefix support any prefix is too many
    always_comb begin
        if (!PREFIX_SUPPORT) begin
            prefix_limit = 3'h0;
        end else if (MAX_PREFIX_COUNT == 2'h0) begin
            prefix_limit = pdc_pkg::PREFIX_LIMIT_FOR_CODE_ZERO;
        end else begin
            prefix_limit = {1'b0, MAX_PREFIX_COUNT};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file: only the control word takes writes
    assign count_clear = rif.wr_en & (rif.wr_addr == pdc_pkg::PREFIX_CHECK_CONTROL_OFS) &
        rif.wdata[pdc_pkg::CONTROL_CLEAR_BIT];

    always_comb begin
        case (rif.rd_addr)
            pdc_pkg::EXPRESS_CAPABILITY_BASE + pdc_pkg::DEVICE_CAPABILITIES_TWO_OFS: begin
                rif.rdata = device_capabilities_two;
            end
            pdc_pkg::MALFORMED_COUNT_OFS: begin
                rif.rdata = {{(32 - pdc_pkg::MALFORMED_COUNT_WIDTH){1'b0}}, malformed_count};
            end
            default: begin
                rif.rdata = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    pdc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rif(rif)
    );

    pdc_prefix_check #(
        .COUNT_WIDTH(pdc_pkg::MALFORMED_COUNT_WIDTH)
    ) u_check (
        .hclk(hclk),
        .hresetn(hresetn),
        .tlp_valid(rx_tlp_valid),
        .tlp_prefix_count(rx_tlp_prefix_count),
        .prefix_limit(prefix_limit),
        .count_clear(count_clear),
        .malformed(rx_tlp_malformed),
        .malformed_count(malformed_count)
    );

endmodule : pdc_caps2_top

// ==== pdc_pkg.sv ====
/*
 * Constants, register map and field layout of the device capabilities two register block.
 * Assumes a 32-bit AHB-Lite bus with word-only access and a 12-bit decoded address window.
 */
package pdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses within the 4 KiB window
    localparam logic [11:0] EXPRESS_CAPABILITY_BASE = 12'h000;
    localparam logic [11:0] DEVICE_CAPABILITIES_TWO_OFS = 12'h024;
    localparam logic [11:0] PREFIX_CHECK_CONTROL_OFS = 12'h080;
    localparam logic [11:0] MALFORMED_COUNT_OFS = 12'h084;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions in device_capabilities_two
    localparam int MAX_PREFIX_COUNT_LSB = 22;
    localparam int PREFIX_SUPPORT_FLAG_BIT = 21;
    localparam int WIDE_FORMAT_SUPPORT_FLAG_BIT = 20;
    localparam int BUFFER_FLUSH_FILL_SUPPORT_LSB = 18;
    localparam int PROCESSING_HINT_COMPLETER_SUPPORT_LSB = 12;
    localparam int LATENCY_REPORTING_SUPPORT_FLAG_BIT = 11;
    localparam int RELAXED_PASSING_FLAG_BIT = 10;
    localparam int WIDE_SWAP_COMPLETER_FLAG_BIT = 9;
    localparam int ATOMIC64_COMPLETER_FLAG_BIT = 8;
    localparam int ATOMIC32_COMPLETER_FLAG_BIT = 7;
    localparam int ATOMIC_ROUTING_FLAG_BIT = 6;
    localparam int ALT_ROUTING_FORWARD_FLAG_BIT = 5;
    localparam int TIMEOUT_DISABLE_SUPPORT_FLAG_BIT = 4;
    localparam int TIMEOUT_RANGES_SUPPORT_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Fixed values and encodings
    localparam logic RELAXED_PASSING_VALUE = 1'b0;
    localparam logic ATOMIC_ROUTING_VALUE = 1'b0;
    localparam logic ALT_ROUTING_FORWARD_VALUE = 1'b0;
    localparam logic TIMEOUT_DISABLE_SUPPORT_VALUE = 1'b1;
    localparam logic [1:0] HINT_NONE = 2'h0;
    localparam logic [1:0] HINT_BASIC = 2'h1;
    localparam logic [1:0] HINT_RESERVED = 2'h2;
    localparam logic [1:0] HINT_BOTH = 2'h3;
    localparam logic [2:0] PREFIX_LIMIT_FOR_CODE_ZERO = 3'h4;
    localparam int CONTROL_CLEAR_BIT = 0;
    localparam int MALFORMED_COUNT_WIDTH = 16;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ_BIT1 = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Reserved hint encoding is never shown to software
    function automatic logic [1:0] pdc_hint_code(input logic [1:0] code);
        pdc_hint_code = (code == HINT_RESERVED) ? HINT_NONE : code;
    endfunction : pdc_hint_code

endpackage : pdc_pkg

// ==== pdc_reg_if.sv ====
/*
 * Carrier between the bus front end and the register file of the capability block.
 * Assumes both sides run on hclk; reads are decoded in the address phase.
 */
`timescale 1ns/10ps
interface pdc_reg_if;
    logic [11:0] rd_addr;
    logic [11:0] wr_addr;
    logic wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport bus (output rd_addr, output wr_addr, output wr_en, output wdata, input rdata);
    modport regs (input rd_addr, input wr_addr, input wr_en, input wdata, output rdata);
endinterface : pdc_reg_if

// ==== pdc_ahb_slave.sv ====
/*
 * AHB-Lite slave front end: zero wait states, always OKAY, word writes only.
 * Assumes a single master and that hready is this slave's own hreadyout.
 */
`timescale 1ns/10ps
module pdc_ahb_slave (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    pdc_reg_if.bus rif
);

    logic active;
    logic dp_write;
    logic [11:0] dp_addr;

    assign active = hsel & hready & htrans[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is captured at the address phase edge so hrdata comes from a flop
    // without a wait state; a read right after a write to the same word sees the old value.
    assign rif.rd_addr = {haddr[11:2], 2'b00};
    assign rif.wr_addr = dp_addr;
    assign rif.wr_en = dp_write;
    assign rif.wdata = hwdata;
    assign hreadyout = 1'b1;
    assign hresp = pdc_pkg::HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            // Sub-word writes are ignored rather than merged
            dp_write <= active & hwrite & (hsize == pdc_pkg::HSIZE_WORD);
            dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= pdc_pkg::DATA_RESET;
        end else if (active & ~hwrite) begin
            hrdata <= rif.rdata;
        end
    end

endmodule : pdc_ahb_slave

// ==== pdc_prefix_check.sv ====
/*
 * Flags received TLPs whose end-end prefix count exceeds the advertised limit.
 * Assumes one TLP descriptor per valid cycle, already parsed upstream.
 */
`timescale 1ns/10ps
module pdc_prefix_check #(
    parameter int COUNT_WIDTH = pdc_pkg::MALFORMED_COUNT_WIDTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Received TLP
    input wire logic tlp_valid,
    input wire logic [2:0] tlp_prefix_count,
    // Limit and control
    input wire logic [2:0] prefix_limit,
    input wire logic count_clear,
    // Result
    output logic malformed,
    output logic [COUNT_WIDTH-1:0] malformed_count
);

    logic hit;
    assign hit = tlp_valid & (tlp_prefix_count > prefix_limit);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            malformed <= 1'b0;
        end else begin
            malformed <= hit;
        end
    end

    // Saturates so software never sees a wrap; a hit in the clear cycle is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            malformed_count <= '0;
        end else if (count_clear) begin
            malformed_count <= hit ? COUNT_WIDTH'(1) : '0;
        end else if (hit && (malformed_count != {COUNT_WIDTH{1'b1}})) begin
            malformed_count <= COUNT_WIDTH'(malformed_count + COUNT_WIDTH'(1));
        end
    end

endmodule : pdc_prefix_check

// ==== pdc_caps2_top_end.sv ====
/*
 * Holds no logic; the capability block top is in pdc_caps2_top.sv.
 * Assumes nothing of its surroundings.
 */

// ==== pdc_tlp_source.sv ====
/*
 * Far-side source of received TLP descriptors for the capability bench.
 * Assumes the block samples one descriptor per rising edge of hclk.
 */
`timescale 1ns/10ps
module pdc_tlp_source (
    // Clock
    input wire logic hclk,
    // Descriptor
    output logic tlp_valid,
    output logic [2:0] tlp_prefix_count
);
    initial tlp_valid = 1'b0;
    initial tlp_prefix_count = 3'h5;

    // Idle count is inverted so a stale value never looks held
    task send(input logic [2:0] count);
        @(posedge hclk);
        tlp_valid <= 1'b1;
        tlp_prefix_count <= count;
        @(posedge hclk);
        tlp_valid <= 1'b0;
        tlp_prefix_count <= ~count;
    endtask : send
endmodule : pdc_tlp_source

// ==== pdc_caps2_checker.sv ====
/*
 * Concurrent checks on the capability block ports.
 * Assumes hready is the block's own hreadyout; bound to every top instance.
 */
`timescale 1ns/10ps
module pdc_caps2_checker #(
    parameter logic [1:0] MAX_PREFIX_COUNT = 2'h1,
    parameter logic PREFIX_SUPPORT = 1'b1,
    parameter logic WIDE_FORMAT_SUPPORT = 1'b0,
    parameter logic [1:0] BUFFER_FLUSH_FILL = 2'h0,
    parameter logic [1:0] PROCESSING_HINT = 2'h0,
    parameter logic LATENCY_REPORTING = 1'b0,
    parameter logic WIDE_SWAP_COMPLETER = 1'b0,
    parameter logic ATOMIC64_COMPLETER = 1'b0,
    parameter logic ATOMIC32_COMPLETER = 1'b0,
    parameter logic [3:0] TIMEOUT_RANGES = 4'h0
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // TLP
    input wire logic rx_tlp_valid,
    input wire logic [2:0] rx_tlp_prefix_count,
    input wire logic rx_tlp_malformed
);
    // Reserved hint code must never reach software
    localparam logic [1:0] HINT = (PROCESSING_HINT == 2'h2) ? 2'h0 : PROCESSING_HINT;
    localparam logic [31:0] CAP = {8'h00, MAX_PREFIX_COUNT, PREFIX_SUPPORT,
        WIDE_FORMAT_SUPPORT, BUFFER_FLUSH_FILL, 4'h0, HINT, LATENCY_REPORTING, 1'b0,
        WIDE_SWAP_COMPLETER, ATOMIC64_COMPLETER, ATOMIC32_COMPLETER, 3'h1, TIMEOUT_RANGES};
    localparam logic [2:0] LIMIT = !PREFIX_SUPPORT ? 3'h0 :
        (MAX_PREFIX_COUNT == 2'h0) ? 3'h4 : {1'b0, MAX_PREFIX_COUNT};
    logic cap_rd;
    logic bad_tlp;
    assign cap_rd = hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h024;
    assign bad_tlp = rx_tlp_valid && rx_tlp_prefix_count > LIMIT;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_cap_word_value: assert property (cap_rd |=> hrdata == CAP)
        else $error("capability word wrong");
    a_reserved_bits_zero: assert property (cap_rd |=> !hrdata[31:24] && !hrdata[17:14])
        else $error("reserved bits set");
    a_hint_code_legal: assert property (cap_rd |=> hrdata[13:12] != 2'h2)
        else $error("reserved hint code shown");
    a_fixed_bits_held: assert property (
        cap_rd |=> hrdata[6:4] == 3'h1 && !hrdata[10])
        else $error("hardwired bits wrong");
    a_limit_field_value: assert property (cap_rd |=> hrdata[23:22] == MAX_PREFIX_COUNT)
        else $error("prefix limit field wrong");
    // A flag may only stay up when the next descriptor is bad as well
    a_excess_flagged: assert property (bad_tlp |=>
        rx_tlp_malformed ##1 (!rx_tlp_malformed || $past(bad_tlp)))
        else $error("excess prefixes not flagged");
    a_no_false_flag: assert property (!bad_tlp |=> !rx_tlp_malformed)
        else $error("malformed flag without cause");
endmodule : pdc_caps2_checker

bind pdc_caps2_top pdc_caps2_checker #(.MAX_PREFIX_COUNT(MAX_PREFIX_COUNT),
    .PREFIX_SUPPORT(PREFIX_SUPPORT), .WIDE_FORMAT_SUPPORT(WIDE_FORMAT_SUPPORT),
    .BUFFER_FLUSH_FILL(BUFFER_FLUSH_FILL), .PROCESSING_HINT(PROCESSING_HINT),
    .LATENCY_REPORTING(LATENCY_REPORTING), .WIDE_SWAP_COMPLETER(WIDE_SWAP_COMPLETER),
    .ATOMIC64_COMPLETER(ATOMIC64_COMPLETER), .ATOMIC32_COMPLETER(ATOMIC32_COMPLETER),
    .TIMEOUT_RANGES(TIMEOUT_RANGES)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_tlp_valid(rx_tlp_valid),
    .rx_tlp_prefix_count(rx_tlp_prefix_count), .rx_tlp_malformed(rx_tlp_malformed));

// ==== test_pdc_caps2_top.sv ====
/*
 * Self-checking bench for the capability block, acting as sole AHB-Lite master.
 * Assumes the TLP source model and the bound checker are compiled alongside.
 */
`timescale 1ns/10ps
module test_pdc_caps2_top;
    // Non-default choices so every field but the limit code and the 64-bit atomic flag is seen away from zero
    localparam logic [1:0] CFG_MAX_PREFIX = 2'h0;
    localparam logic CFG_WIDE_FORMAT = 1'b1;
    localparam logic [1:0] CFG_FLUSH_FILL = 2'h2;
    localparam logic [1:0] CFG_HINT = 2'h3;
    localparam logic CFG_LATENCY = 1'b1;
    localparam logic CFG_WIDE_SWAP = 1'b1;
    localparam logic CFG_ATOMIC32 = 1'b1;
    localparam logic [3:0] CFG_RANGES = 4'hA;
    // Second block: no prefix support, reserved hint code asked for
    localparam logic CFG2_PREFIX_SUPPORT = 1'b0;
    localparam logic [1:0] CFG2_HINT = 2'h2;
    localparam logic [2:0] LIMIT = 3'h4;
    localparam logic [2:0] LIMIT2 = 3'h0;
    localparam logic [31:0] EXP_CAP = {8'h00, 2'h0, 1'b1, 1'b1, 2'h2, 4'h0, 2'h3, 1'b1,
        1'b0, 1'b1, 1'b0, 1'b1, 3'h1, 4'hA};
    // Limit code one, prefix bit clear, hint shown as none, timeout-disable bit set
    localparam logic [31:0] EXP_CAP2 = 32'h0040_0010;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [31:0] rd2;
    wire logic hready;
    wire logic hready2;
    wire logic hresp;
    wire logic hresp2;
    wire logic [31:0] hrdata;
    wire logic [31:0] hrdata2;
    wire logic rx_tlp_valid;
    wire logic [2:0] rx_tlp_prefix_count;
    wire logic rx_tlp_malformed;
    wire logic rx_tlp_malformed2;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    initial forever #4 hclk = ~hclk;

    pdc_caps2_top #(.MAX_PREFIX_COUNT(CFG_MAX_PREFIX), .WIDE_FORMAT_SUPPORT(CFG_WIDE_FORMAT),
        .BUFFER_FLUSH_FILL(CFG_FLUSH_FILL), .PROCESSING_HINT(CFG_HINT),
        .LATENCY_REPORTING(CFG_LATENCY), .WIDE_SWAP_COMPLETER(CFG_WIDE_SWAP),
        .ATOMIC32_COMPLETER(CFG_ATOMIC32), .TIMEOUT_RANGES(CFG_RANGES))
    u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rx_tlp_valid(rx_tlp_valid),
        .rx_tlp_prefix_count(rx_tlp_prefix_count), .rx_tlp_malformed(rx_tlp_malformed));

    // Shares the bus and the TLP source; answers the same transfers in parallel
    pdc_caps2_top #(.PREFIX_SUPPORT(CFG2_PREFIX_SUPPORT), .PROCESSING_HINT(CFG2_HINT))
    u_dut_nopfx (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready2),
        .hreadyout(hready2), .hresp(hresp2), .hrdata(hrdata2), .rx_tlp_valid(rx_tlp_valid),
        .rx_tlp_prefix_count(rx_tlp_prefix_count), .rx_tlp_malformed(rx_tlp_malformed2));

    pdc_tlp_source u_src (.hclk(hclk), .tlp_valid(rx_tlp_valid),
        .tlp_prefix_count(rx_tlp_prefix_count));

    ////////////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One single transfer at the hsize the caller has set; waits on hready, never on a fixed count
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        rd2 = hrdata2;
    endtask : bus

    ////////////////////////////////////////////////////////////////////////////////
    task t_cap_word;
        bus(1'b0, 12'h024, 32'h0);
        check("capability word", EXP_CAP, rd);
        check("capability word no prefix", EXP_CAP2, rd2);
    endtask : t_cap_word

    task t_writes_ignored;
        bus(1'b1, 12'h024, 32'hFFFF_FFFF);
        bus(1'b0, 12'h024, 32'h0);
        check("capability after write", EXP_CAP, rd);
        check("capability no prefix after write", EXP_CAP2, rd2);
        bus(1'b1, 12'h100, 32'hFFFF_FFFF);
        bus(1'b0, 12'h100, 32'h0);
        check("unmapped word", 32'h0, rd);
        check("unmapped word no prefix", 32'h0, rd2);
    endtask : t_writes_ignored

    // Limit code zero means four; without prefix support any prefix is too many
    task t_prefix_limit;
        for (int c = 0; c < 8; c++) begin
            u_src.send(c[2:0]);
            #1;
            check("malformed flag", {31'h0, c > LIMIT}, {31'h0, rx_tlp_malformed});
            check("flag no prefix", {31'h0, c > LIMIT2}, {31'h0, rx_tlp_malformed2});
        end
        bus(1'b0, 12'h084, 32'h0);
        check("malformed count", 32'h3, rd);
        check("count no prefix", 32'h7, rd2);
        // A byte-sized write to the control word must not clear
        hsize <= 3'h0;
        bus(1'b1, 12'h080, 32'h1);
        hsize <= 3'h2;
        bus(1'b0, 12'h084, 32'h0);
        check("count after byte write", 32'h3, rd);
        bus(1'b1, 12'h080, 32'h1);
        bus(1'b0, 12'h084, 32'h0);
        check("count after clear", 32'h0, rd);
        check("count no prefix after clear", 32'h0, rd2);
    endtask : t_prefix_limit

    task t_reset_mid;
        u_src.send(3'h7);
        bus(1'b0, 12'h084, 32'h0);
        check("count before reset", 32'h1, rd);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 12'h084, 32'h0);
        check("count after reset", 32'h0, rd);
        check("count no prefix after reset", 32'h0, rd2);
        t_cap_word();
    endtask : t_reset_mid

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_cap_word();
        t_writes_ignored();
        t_prefix_limit();
        t_reset_mid();
        complete_run();
    end
endmodule : test_pdc_caps2_top
